/* design/sscf_defs.vh */
// Register offsets, field positions, reset values and frame constants
`ifndef SSCF_DEFS_VH
`define SSCF_DEFS_VH
// Register indices on the local port
`define SSCF_REG_CTRL 3'h0
`define SSCF_REG_GPO 3'h1
`define SSCF_REG_MODCFG 3'h2
`define SSCF_REG_DEV 3'h3
`define SSCF_REG_STATUS 3'h4
`define SSCF_REG_OFFLO 3'h5
`define SSCF_REG_OFFHI 3'h6
// Control register bits
`define SSCF_CTRL_SOFT 0
`define SSCF_CTRL_ENABLE 1
`define SSCF_CTRL_PATH 2
`define SSCF_CTRL_RESET 3
`define SSCF_CTRL_FULL_DUPLEX_SELECT 4
`define SSCF_CTRL_CPOUT0 5
`define SSCF_CTRL_CPOUT1 6
`define SSCF_CTRL_RST 7'h00
// Output register fields
`define SSCF_GPO_P1_LSB 0
`define SSCF_GPO_P2_LSB 8
`define SSCF_GPO_RST 16'h0000
// Modulation config fields
`define SSCF_MOD_SETUP_LSB 0
`define SSCF_MOD_STEP_LSB 2
`define SSCF_MODCFG_RST 6'h00
`define SSCF_SETUP_FSK 2'h3
`define SSCF_SETUP_CONT 2'h1
`define SSCF_DEV_RST 16'h0000
// Fsk select on output pin index 2
`define SSCF_FSK_PIN 2
// Serial frame: 2 chip address, 3 register, 16 data bits
`define SSCF_FRAME_BITS 5'h15
`endif

/* design/sscf_ctrl.v */
// Serial control, multi-chip addressing, output pins and modulation offset
//
// How it works
// - Software-control bit set: enable, path and reset come from control register.
// - Under software control the three hardware control lines are ignored.
// - Under software control the two control pins become general outputs.
// - Up to four chips share the serial bus, addressed by two strap pins.
// - After reset every serial write is accepted regardless of strap pins.
// - Once software control is set, only frames matching the straps are taken.
// - Output pins come from path 1 or path 2 field by path selection.
// - Setup field 11 selects FSK; output pin 2 becomes the select input.
// - In FSK the select input picks zero offset or programmed deviation.
// - Offset is signed deviation word shifted by step exponent, units fpd/2^16.
// - Setup field 01 selects continuous modulation with the same fields.
// - In continuous mode a new deviation word updates the offset at once.
// - Path low: bank1/mixer1; high: bank2/mixer2; full duplex: both mixers.
// - Reset line low, without software control, returns registers, serial receiver and outputs, addressing too, to power-up.
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ns
`include "sscf_defs.vh"
module sscf_ctrl #(
    parameter NGPO = 6
) (
    input wire clock,
    input wire rst_n,
    input wire [2:0] regAddr,
    input wire [15:0] regWrData,
    input wire regWr,
    input wire regRd,
    output reg [15:0] regRdData,
    input wire serialClk,
    input wire serialData,
    input wire serialEnN,
    input wire chipEnableLine,
    input wire pathSelectLine,
    input wire activeLowResetLineN,
    input wire addressStrapLow,
    input wire addressStrapHigh,
    input wire [NGPO-1:0] gpPinIn,
    output reg [NGPO-1:0] gpPinOut,
    output reg [NGPO-1:0] gpPinOe,
    output reg [1:0] ctrlPinOut,
    output reg [1:0] ctrlPinOe,
    output reg chipEnable,
    output reg bank2Select,
    output reg mixer1Active,
    output reg mixer2Active,
    output reg fskActive,
    output reg [31:0] freqOffset
);
    // Pin synchronisers: clk, data, en, enable, path, reset, strap lo/hi, fsk
    reg [8:0] pinMeta_q;
    reg [8:0] pinSync_q;
    wire [8:0] pinRaw = {gpPinIn[`SSCF_FSK_PIN], addressStrapHigh, addressStrapLow,
        activeLowResetLineN, pathSelectLine, chipEnableLine, serialEnN,
        serialData, serialClk};
    // Reset to idle pin levels: serial enable high, reset line high, all else low.
    // Any other value would fake a reset-line pulse or a frame edge after reset.
    always @(posedge clock) begin
        if (!rst_n) begin
            pinMeta_q <= 9'h024;
            pinSync_q <= 9'h024;
        end else begin
            pinMeta_q <= pinRaw;
            pinSync_q <= pinMeta_q;
        end
    end
    wire sClk = pinSync_q[0];
    wire sData = pinSync_q[1];
    wire sEnN = pinSync_q[2];
    wire hwEnable = pinSync_q[3];
    wire hwPath = pinSync_q[4];
    wire hwResetN = pinSync_q[5];
    wire [1:0] strap = pinSync_q[7:6];
    wire fskSel = pinSync_q[8];

    // Registers
    reg [6:0] ctrl_q;
    reg [6:0] ctrl_d;
    reg [15:0] gpo_q;
    reg [15:0] gpo_d;
    reg [5:0] modCfg_q;
    reg [5:0] modCfg_d;
    reg [15:0] dev_q;
    reg [15:0] dev_d;

    wire softCtrl = ctrl_q[`SSCF_CTRL_SOFT];
    // Hardware lines have no effect while software owns control
    wire effEnable = softCtrl ? ctrl_q[`SSCF_CTRL_ENABLE] : hwEnable;
    wire effPath = softCtrl ? ctrl_q[`SSCF_CTRL_PATH] : hwPath;
    wire softReset = softCtrl & ctrl_q[`SSCF_CTRL_RESET];
    wire hwReset = ~softCtrl & ~hwResetN;
    wire digReset = ~rst_n | hwReset | softReset;

    wire [1:0] modulation_setup_field = modCfg_q[`SSCF_MOD_SETUP_LSB +: 2];
    wire [3:0] deviation_step_exponent = modCfg_q[`SSCF_MOD_STEP_LSB +: 4];
    wire fskMode = (modulation_setup_field == `SSCF_SETUP_FSK);
    wire contMode = (modulation_setup_field == `SSCF_SETUP_CONT);

    // Serial receiver state
    reg sClkPrev_q;
    reg sEnPrev_q;
    reg [20:0] shift_q;
    reg [4:0] bitCnt_q;
    reg serWr_q;
    reg [2:0] serAddr_q;
    reg [15:0] serData_q;

    // Serial shift: bits on rising serial clock while enable is low
    // Frame commits when enable rises, only if exactly full length
    always @(posedge clock) begin
        if (digReset) begin
            sClkPrev_q <= 1'b0;
            sEnPrev_q <= 1'b1;
            shift_q <= 21'h00_0000;
            bitCnt_q <= 5'h00;
            serWr_q <= 1'b0;
            serAddr_q <= 3'h0;
            serData_q <= 16'h0000;
        end else begin
            sClkPrev_q <= sClk;
            sEnPrev_q <= sEnN;
            serWr_q <= 1'b0;
            if (sEnN) begin
                bitCnt_q <= 5'h00;
            end else if (sClk && !sClkPrev_q) begin
                shift_q <= {shift_q[19:0], sData};
                if (bitCnt_q != 5'h1F) begin
                    bitCnt_q <= bitCnt_q + 5'h01;
                end
            end
            if (sEnN && !sEnPrev_q && bitCnt_q == `SSCF_FRAME_BITS) begin
                // Broadcast until software control is set, then strap match
                if (!softCtrl || shift_q[20:19] == strap) begin
                    serWr_q <= 1'b1;
                end
                serAddr_q <= shift_q[18:16];
                serData_q <= shift_q[15:0];
            end
        end
    end

    // Register next values; a serial write lands after a local one
    always @* begin
        ctrl_d = ctrl_q;
        gpo_d = gpo_q;
        modCfg_d = modCfg_q;
        dev_d = dev_q;
        if (regWr) begin
            case (regAddr)
                `SSCF_REG_CTRL: ctrl_d = regWrData[6:0];
                `SSCF_REG_GPO: gpo_d = regWrData;
                `SSCF_REG_MODCFG: modCfg_d = regWrData[5:0];
                `SSCF_REG_DEV: dev_d = regWrData;
                default: ;
            endcase
        end
        if (serWr_q) begin
            case (serAddr_q)
                `SSCF_REG_CTRL: ctrl_d = serData_q[6:0];
                `SSCF_REG_GPO: gpo_d = serData_q;
                `SSCF_REG_MODCFG: modCfg_d = serData_q[5:0];
                `SSCF_REG_DEV: dev_d = serData_q;
                default: ;
            endcase
        end
    end

    // Register update; any reset source clears addressing state too
    always @(posedge clock) begin
        if (digReset) begin
            ctrl_q <= `SSCF_CTRL_RST;
            gpo_q <= `SSCF_GPO_RST;
            modCfg_q <= `SSCF_MODCFG_RST;
            dev_q <= `SSCF_DEV_RST;
        end else begin
            ctrl_q <= ctrl_d;
            gpo_q <= gpo_d;
            modCfg_q <= modCfg_d;
            dev_q <= dev_d;
        end
    end

    // Offset: sign-extend deviation, scale by 2^step
    wire [31:0] devExt = {{16{dev_q[15]}}, dev_q};
    wire [31:0] devScaled = devExt << deviation_step_exponent;
    reg [31:0] offsetSel;
    always @* begin
        if (fskMode) begin
            offsetSel = fskSel ? devScaled : 32'h0000_0000;
        end else if (contMode) begin
            offsetSel = devScaled;
        end else begin
            offsetSel = 32'h0000_0000;
        end
    end

    // Path-selected output levels; fsk pin released as an input
    wire [NGPO-1:0] gpoLevel = effPath ? gpo_q[`SSCF_GPO_P2_LSB +: NGPO]
                                       : gpo_q[`SSCF_GPO_P1_LSB +: NGPO];
    reg [NGPO-1:0] gpoEnable;
    always @* begin
        gpoEnable = {NGPO{1'b1}};
        if (fskMode) begin
            gpoEnable[`SSCF_FSK_PIN] = 1'b0;
        end
    end

    // Read data one cycle after the strobe; unmapped reads zero
    always @(posedge clock) begin
        if (!rst_n) begin
            regRdData <= 16'h0000;
        end else if (regRd) begin
            case (regAddr)
                `SSCF_REG_CTRL: regRdData <= {9'h000, ctrl_q};
                `SSCF_REG_GPO: regRdData <= gpo_q;
                `SSCF_REG_MODCFG: regRdData <= {10'h000, modCfg_q};
                `SSCF_REG_DEV: regRdData <= dev_q;
                `SSCF_REG_STATUS: regRdData <= {9'h000, fskSel, strap, effPath,
                    effEnable, fskMode, softCtrl};
                `SSCF_REG_OFFLO: regRdData <= freqOffset[15:0];
                `SSCF_REG_OFFHI: regRdData <= freqOffset[31:16];
                default: regRdData <= 16'h0000;
            endcase
        end else begin
            regRdData <= 16'h0000;
        end
    end

    // Registered outputs
    always @(posedge clock) begin
        if (digReset) begin
            gpPinOut <= {NGPO{1'b0}};
            gpPinOe <= {NGPO{1'b0}};
            ctrlPinOut <= 2'h0;
            ctrlPinOe <= 2'h0;
            chipEnable <= 1'b0;
            bank2Select <= 1'b0;
            mixer1Active <= 1'b0;
            mixer2Active <= 1'b0;
            fskActive <= 1'b0;
            freqOffset <= 32'h0000_0000;
        end else begin
            gpPinOut <= gpoLevel;
            gpPinOe <= gpoEnable;
            // Control pins only drive once software owns control
            ctrlPinOut <= {ctrl_q[`SSCF_CTRL_CPOUT1], ctrl_q[`SSCF_CTRL_CPOUT0]};
            ctrlPinOe <= {softCtrl, softCtrl};
            chipEnable <= effEnable;
            bank2Select <= effPath;
            mixer1Active <= ~effPath | ctrl_q[`SSCF_CTRL_FULL_DUPLEX_SELECT];
            mixer2Active <= effPath | ctrl_q[`SSCF_CTRL_FULL_DUPLEX_SELECT];
            fskActive <= fskMode;
            freqOffset <= offsetSel;
        end
    end
endmodule // sscf_ctrl

/* bench/sscf_host_model.sv */
// Host model driving frames onto the three-wire serial bus
`timescale 1ns/1ns
module sscf_host_model (
    output logic sClk,
    output logic sData,
    output logic sEnN
);
    // Idle bus: clock stands low, enable high
    initial begin
        sClk = 1'b0;
        sData = 1'b0;
        sEnN = 1'b1;
    end
    // One frame, msb first; 400 ns bit keeps each phase four system clocks long
    task automatic sendFrame(input logic [20:0] f);
        sEnN = 1'b0;
        for (int i = 20; i >= 0; i--) begin
            sData = f[i];
            #200 sClk = 1'b1;
            #200 sClk = 1'b0;
        end
        #200 sEnN = 1'b1;
        sData = ~sData; // Released line shows no stale bit
    endtask
endmodule // sscf_host_model

/* bench/sscf_checker.sv */
// Port assertions for the serial control block
`timescale 1ns/1ns
module sscf_checker #(
    parameter NGPO = 6
) (
    input wire clock,
    input wire rst_n,
    input wire [2:0] regAddr,
    input wire regRd,
    input wire [15:0] regRdData,
    input wire [NGPO-1:0] gpPinIn,
    input wire [NGPO-1:0] gpPinOe,
    input wire [1:0] ctrlPinOe,
    input wire bank2Select,
    input wire mixer1Active,
    input wire mixer2Active,
    input wire fskActive,
    input wire [31:0] freqOffset
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic [1:0] upCnt_q;
    // Derived outputs only settle three edges after reset release
    always @(posedge clock) begin
        if (!rst_n) begin
            upCnt_q <= 2'h0;
        end else if (upCnt_q != 2'h3) begin
            upCnt_q <= upCnt_q + 2'h1;
        end
    end
    sequence fskLow;
        (fskActive && !gpPinIn[2]) [*5];
    endsequence
    rdIdle_a: assert property (!$past(regRd) |-> regRdData == 16'h0000)
        else $error("read data not zero outside read slot");
    unmapRd_a: assert property (regRd && regAddr == 3'h7 |=> regRdData == 16'h0000)
        else $error("unmapped read returned data");
    // All-zero output enables mark an internal reset cycle, where mixers are both off
    mixOne_a: assert property (upCnt_q == 2'h3 && gpPinOe != 6'h00 && !mixer1Active
        |-> mixer2Active && bank2Select)
        else $error("mixer 1 off without path 2");
    mixTwo_a: assert property (upCnt_q == 2'h3 && gpPinOe != 6'h00 && !mixer2Active
        |-> mixer1Active && !bank2Select)
        else $error("mixer 2 off without path 1");
    fskPinIn_a: assert property ($rose(fskActive) |-> ##[0:1] !gpPinOe[2])
        else $error("fsk pin still driven");
    fskZero_a: assert property (fskLow |-> freqOffset == 32'h0000_0000)
        else $error("offset not zero with select low");
    fskSync_a: assert property (fskActive && $rose(gpPinIn[2]) |=> $stable(freqOffset))
        else $error("fsk select used without synchroniser");
    ctrlPair_a: assert property (ctrlPinOe == 2'h0 || ctrlPinOe == 2'h3)
        else $error("control pins not enabled together");
endmodule // sscf_checker

bind sscf_ctrl sscf_checker #(.NGPO(NGPO)) i_checker (.clock(clock), .rst_n(rst_n),
    .regAddr(regAddr), .regRd(regRd), .regRdData(regRdData), .gpPinIn(gpPinIn),
    .gpPinOe(gpPinOe), .ctrlPinOe(ctrlPinOe), .bank2Select(bank2Select),
    .mixer1Active(mixer1Active), .mixer2Active(mixer2Active), .fskActive(fskActive),
    .freqOffset(freqOffset));

/* bench/tb_top.sv */
// Directed bench for the serial control block
`timescale 1ns/1ns
`include "sscf_defs.vh"
module tb_top;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] regAddr = 3'h0;
    logic [15:0] regWrData = 16'h0000;
    logic regWr = 1'b0, regRd = 1'b0, ceLine = 1'b0, pathLine = 1'b0, rstLineN = 1'b1;
    logic [1:0] strap = 2'h2;
    logic [5:0] pinIn = 6'h00;
    logic [15:0] regRdData;
    logic sClk, sData, sEnN, ce, b2, m1, m2, fsk;
    logic [5:0] gpOut, gpOe;
    logic [1:0] cpOut, cpOe;
    logic [31:0] offs;
    int miscompares = 0;
    int num_checks = 0;
    // 20 MHz system clock
    always #25 clock = ~clock;
    sscf_host_model i_host (.sClk(sClk), .sData(sData), .sEnN(sEnN));
    sscf_ctrl #(.NGPO(6)) i_dut (.clock(clock), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .serialClk(sClk), .serialData(sData), .serialEnN(sEnN), .chipEnableLine(ceLine),
        .pathSelectLine(pathLine), .activeLowResetLineN(rstLineN),
        .addressStrapLow(strap[0]), .addressStrapHigh(strap[1]), .gpPinIn(pinIn),
        .gpPinOut(gpOut), .gpPinOe(gpOe), .ctrlPinOut(cpOut), .ctrlPinOe(cpOe),
        .chipEnable(ce), .bank2Select(b2), .mixer1Active(m1), .mixer2Active(m2),
        .fskActive(fsk), .freqOffset(offs));
    // Verdict and end of run
    task automatic finish_test();
        if (miscompares == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Settle just past an edge so registered outputs have landed
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clock);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clock);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [15:0] exp);
        @(posedge clock);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clock);
        regRd <= 1'b0;
        #1 chk(regRdData, exp);
    endtask
    // Serial frame, then room for sync and commit
    task automatic ser(input logic [1:0] ad, input logic [2:0] r, input logic [15:0] d);
        i_host.sendFrame({ad, r, d});
        tick(10);
    endtask
    // Hang guard, far beyond the four frames of the run
    initial begin
        #400000;
        miscompares++;
        finish_test();
    end
    initial begin
        tick(10);
        rst_n <= 1'b1;
        rd(`SSCF_REG_CTRL, 16'h0000);
        pathLine <= 1'b1;
        tick(6);
        chk({b2, m1, m2}, 3'b101);
        wr(`SSCF_REG_CTRL, 16'h0010);
        tick(2);
        chk({m1, m2}, 2'b11);
        ser(2'h1, `SSCF_REG_GPO, 16'h2A15);
        rd(`SSCF_REG_GPO, 16'h2A15);
        chk(gpOut, 6'h2A);
        // Software control: hardware lines moved but ignored
        wr(`SSCF_REG_CTRL, 16'h0031);
        rstLineN <= 1'b0;
        ceLine <= 1'b1;
        tick(6);
        chk({ce, b2, gpOut}, {2'b00, 6'h15});
        chk({cpOut, cpOe}, 4'b0111);
        rd(`SSCF_REG_CTRL, 16'h0031);
        rstLineN <= 1'b1;
        ser(2'h1, `SSCF_REG_GPO, 16'h0000);
        rd(`SSCF_REG_GPO, 16'h2A15);
        ser(2'h2, `SSCF_REG_GPO, 16'h0115);
        rd(`SSCF_REG_GPO, 16'h0115);
        wr(`SSCF_REG_CTRL, 16'h0035);
        tick(2);
        chk({b2, gpOut}, {1'b1, 6'h01});
        // Continuous modulation, step exponent 2
        wr(`SSCF_REG_MODCFG, 16'h0009);
        wr(`SSCF_REG_DEV, 16'hFFFE);
        tick(1);
        chk(offs, 32'hFFFF_FFF8);
        wr(`SSCF_REG_DEV, 16'h0003);
        tick(1);
        chk(offs, 32'h0000_000C);
        rd(`SSCF_REG_OFFLO, 16'h000C);
        rd(`SSCF_REG_OFFHI, 16'h0000);
        // Binary keying through the select pin
        wr(`SSCF_REG_MODCFG, 16'h0003);
        wr(`SSCF_REG_DEV, 16'h0005);
        tick(6);
        chk({fsk, gpOe[2]}, 2'b10);
        chk(offs, 32'h0000_0000);
        pinIn <= 6'h04;
        tick(6);
        chk(offs, 32'h0000_0005);
        // Self-clearing register reset brings back broadcast
        wr(`SSCF_REG_CTRL, 16'h0009);
        tick(2);
        rd(`SSCF_REG_CTRL, 16'h0000);
        chk({ce, b2}, 2'b11);
        ser(2'h1, `SSCF_REG_GPO, 16'h0203);
        rd(`SSCF_REG_GPO, 16'h0203);
        rd(3'h7, 16'h0000);
        finish_test();
    end
endmodule // tb_top
